// File: hdl/ess_exec.sv
// Execution sequencer for the extended data-memory skip, subtract and swap operations.
// Assumes a data memory with one-cycle read latency and a core that owns the
// accumulator and status flags and applies the write strobes given here.
//
// Notes on behaviour
// - Increment memory byte, write back, skip next when the sum is zero.
// - A taken skip inserts one dummy cycle replacing the fetched next instruction.
// - Accumulator variant: incremented value to accumulator, memory untouched, skip on zero.
// - Skip when the memory byte is nonzero, otherwise continue normally.
// - Subtract: accumulator minus memory byte goes to the accumulator.
// - Memory subtract: difference written to the byte, accumulator unchanged.
// - Carry cleared on borrow, set when the difference is zero or positive.
// - Subtracts update all six status flags; no other operation writes them.
// - Nibble exchange swaps byte halves and writes the byte back.
`timescale 1ns/1ps
module ess_exec
	import ess_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	// Request from the instruction sequencer
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire ess_req_type           req,
	// Completion towards the sequencer
	output logic                       done,
	output logic                       skip_dummy,
	// Data memory
	output logic                       mem_rd_en,
	output logic [ESS_ADDR_W-1:0]      mem_addr,
	input  wire logic [ESS_DATA_W-1:0] mem_rdata,
	output logic                       mem_we,
	output logic [ESS_DATA_W-1:0]      mem_wdata,
	// Accumulator
	input  wire logic [ESS_DATA_W-1:0] acc_in,
	output logic                       acc_we,
	output logic [ESS_DATA_W-1:0]      acc_wdata,
	// Status flags
	input  wire ess_flags_type         flags_in,
	output logic                       flags_we,
	output ess_flags_type              flags_wdata
);

	//----------------------------------------
	// Elaboration checks
	//----------------------------------------
	if (ESS_DATA_W != 2 * ESS_NIB_W)
	begin : g_bad_width
		$error("Data width must be two nibbles");
	end
	if (ESS_NIB_W < 1)
	begin : g_bad_nibble
		$error("Nibble width must be at least one bit");
	end
	if (ESS_ADDR_W < 1)
	begin : g_bad_addr
		$error("Address width must be at least one bit");
	end
	if ($bits(ess_flags_type) != 6)
	begin : g_bad_flags
		$error("Flag carrier must hold six status flags");
	end

	//----------------------------------------
	// State
	//----------------------------------------
	// Accept, read, operate, commit; the dummy cycle follows only a taken skip
	typedef enum logic [4:0]
	{
		ST_IDLE   = 5'b00001,
		ST_READ   = 5'b00010,
		ST_EXEC   = 5'b00100,
		ST_COMMIT = 5'b01000,
		ST_DUMMY  = 5'b10000
	} ess_state_type;

	ess_state_type            state_q;
	ess_state_type            state_d;
	ess_req_type              req_q;
	logic [ESS_DATA_W-1:0]    res_q;
	ess_flags_type            flg_q;
	logic                     skip_q;

	//----------------------------------------
	// Datapath
	//----------------------------------------
	logic [ESS_DATA_W-1:0]    alu_result;
	ess_flags_type            alu_flags;
	logic                     alu_skip;

	ess_alu u_alu
	(
		.op        (req_q.op),
		.acc       (acc_in),
		.mem       (mem_rdata),
		.flags_in  (flags_in),
		.result    (alu_result),
		.flags_out (alu_flags),
		.skip      (alu_skip)
	);

	//----------------------------------------
	// Operation decode
	//----------------------------------------
	wire logic is_inc_mem  = (req_q.op == ESS_OP_INC_SKIP_ZERO_MEM);
	wire logic is_inc_acc  = (req_q.op == ESS_OP_INC_SKIP_ZERO_TO_ACC);
	wire logic is_sub_acc  = (req_q.op == ESS_OP_SUB_MEM_FROM_ACC);
	wire logic is_sub_mem  = (req_q.op == ESS_OP_SUB_MEM_FROM_ACC_TO_MEM);
	wire logic is_swap_mem = (req_q.op == ESS_OP_NIBBLE_EXCHANGE_MEM);

	// Destination of the committed result
	wire logic op_to_mem   = is_inc_mem
	                       | is_sub_mem
	                       | is_swap_mem;
	wire logic op_to_acc   = is_inc_acc
	                       | is_sub_acc;
	// Only the subtracts touch the flags
	wire logic op_to_flags = is_sub_acc
	                       | is_sub_mem;

	wire logic in_idle   = (state_q == ST_IDLE);
	wire logic in_read   = (state_q == ST_READ);
	wire logic in_exec   = (state_q == ST_EXEC);
	wire logic in_commit = (state_q == ST_COMMIT);
	wire logic in_dummy  = (state_q == ST_DUMMY);
	wire logic accept    = ce & in_idle & req_valid;
	wire logic commit_now = ce & in_commit;
	wire logic capture    = ce & in_exec;

	//----------------------------------------
	// Handshake and strobes
	//----------------------------------------
	assign req_ready  = in_idle;
	assign mem_rd_en  = ce & in_read;
	assign mem_we     = commit_now & op_to_mem;
	assign acc_we     = commit_now & op_to_acc;
	assign flags_we   = commit_now & op_to_flags;
	assign done       = ce & ((in_commit & ~skip_q) | in_dummy);
	assign skip_dummy = ce & in_dummy;

	//----------------------------------------
	// Result outputs
	//----------------------------------------
	// All straight from flops, stable for the whole commit
	assign mem_addr    = req_q.addr;
	assign mem_wdata   = res_q;
	assign acc_wdata   = res_q;
	assign flags_wdata = flg_q;

	//----------------------------------------
	// Next state
	//----------------------------------------
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (req_valid)
					state_d = ST_READ;
			ST_READ:
				state_d = ST_EXEC;
			ST_EXEC:
				state_d = ST_COMMIT;
			ST_COMMIT:
				state_d = skip_q ? ST_DUMMY : ST_IDLE;
			ST_DUMMY:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	//----------------------------------------
	// Registers
	//----------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_q <= ST_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			req_q <= '{op: ESS_OP_INC_SKIP_ZERO_MEM, addr: ESS_ADDR_RST};
		else if (accept)
			req_q <= req;
	end

	//----------------------------------------
	// Result registers
	//----------------------------------------
	// Captured in the cycle the memory byte arrives
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			res_q <= ESS_DATA_RST;
		else if (capture)
			res_q <= alu_result;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			flg_q <= ESS_FLAGS_RST;
		else if (capture)
			flg_q <= alu_flags;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			skip_q <= 1'b0;
		else if (capture)
			skip_q <= alu_skip;
	end

endmodule

// File: hdl/ess_pkg.sv
// Shared types and constants for the extended skip/subtract/swap execution block.
// Assumes an 8-bit data memory and accumulator on a single core clock.
package ess_pkg;

	//----------------------------------------
	// Widths and reset values
	//----------------------------------------
	localparam int          ESS_DATA_W   = 8;
	localparam int          ESS_ADDR_W   = 8;
	localparam int          ESS_NIB_W    = 4;
	localparam logic [7:0]  ESS_DATA_RST = 8'h00;
	localparam logic [7:0]  ESS_ADDR_RST = 8'h00;
	localparam logic [7:0]  ESS_ONE      = 8'h01;

	//----------------------------------------
	// Operations
	//----------------------------------------
	typedef enum logic [2:0]
	{
		ESS_OP_INC_SKIP_ZERO_MEM       = 3'h0,
		ESS_OP_INC_SKIP_ZERO_TO_ACC    = 3'h1,
		ESS_OP_SKIP_IF_NONZERO         = 3'h2,
		ESS_OP_SUB_MEM_FROM_ACC        = 3'h3,
		ESS_OP_SUB_MEM_FROM_ACC_TO_MEM = 3'h4,
		ESS_OP_NIBBLE_EXCHANGE_MEM     = 3'h5
	} ess_op_type;

	//----------------------------------------
	// Carriers
	//----------------------------------------
	typedef struct packed
	{
		ess_op_type            op;
		logic [ESS_ADDR_W-1:0] addr;
	} ess_req_type;

	typedef struct packed
	{
		logic overflow_flag;
		logic zero;
		logic half_carry_flag;
		logic carry;
		logic signed_compare_flag;
		logic chained_zero_flag;
	} ess_flags_type;

	localparam ess_flags_type ESS_FLAGS_RST = '{default: 1'b0};

	//----------------------------------------
	// Helpers
	//----------------------------------------
	function automatic logic ess_is_zero(input logic [ESS_DATA_W-1:0] v);
		ess_is_zero = (v == ESS_DATA_RST);
	endfunction

endpackage

// File: hdl/ess_alu.sv
// Combinational datapath: increment, subtract, nibble exchange, skip decision.
// Assumes operands are stable for the cycle in which the caller samples the result.
`timescale 1ns/1ps
module ess_alu
	import ess_pkg::*;
(
	// Operation and operands
	input  wire ess_op_type            op,
	input  wire logic [ESS_DATA_W-1:0] acc,
	input  wire logic [ESS_DATA_W-1:0] mem,
	input  wire ess_flags_type         flags_in,
	// Results
	output logic [ESS_DATA_W-1:0]      result,
	output ess_flags_type              flags_out,
	output logic                       skip
);

	//----------------------------------------
	// Arithmetic
	//----------------------------------------
	wire logic [ESS_DATA_W-1:0] inc_val = ESS_DATA_W'(mem + ESS_ONE);
	wire logic [ESS_DATA_W:0]   diff    = {1'b0, acc} - {1'b0, mem};
	wire logic [ESS_NIB_W:0]    ndiff   = {1'b0, acc[ESS_NIB_W-1:0]} - {1'b0, mem[ESS_NIB_W-1:0]};
	wire logic [ESS_DATA_W-1:0] sub_val = diff[ESS_DATA_W-1:0];
	wire logic [ESS_DATA_W-1:0] swp_val = {mem[ESS_NIB_W-1:0], mem[ESS_DATA_W-1:ESS_NIB_W]};
	wire logic                  sub_ov  = (acc[ESS_DATA_W-1] ^ mem[ESS_DATA_W-1])
	                                    & (acc[ESS_DATA_W-1] ^ sub_val[ESS_DATA_W-1]);
	wire logic                  sub_z   = ess_is_zero(sub_val);

	//----------------------------------------
	// Selection
	//----------------------------------------
	always_comb
	begin
		result    = mem;
		flags_out = flags_in;
		skip      = 1'b0;
		unique case (op)
			ESS_OP_INC_SKIP_ZERO_MEM, ESS_OP_INC_SKIP_ZERO_TO_ACC:
			begin
				result = inc_val;
				skip   = ess_is_zero(inc_val);
			end
			ESS_OP_SKIP_IF_NONZERO:
				skip = !ess_is_zero(mem);
			ESS_OP_SUB_MEM_FROM_ACC, ESS_OP_SUB_MEM_FROM_ACC_TO_MEM:
			begin
				result                        = sub_val;
				flags_out.carry               = ~diff[ESS_DATA_W];
				flags_out.overflow_flag       = sub_ov;
				flags_out.zero                = sub_z;
				flags_out.half_carry_flag     = ~ndiff[ESS_NIB_W];
				flags_out.signed_compare_flag = sub_ov ^ sub_val[ESS_DATA_W-1];
				flags_out.chained_zero_flag   = sub_z;
			end
			ESS_OP_NIBBLE_EXCHANGE_MEM:
				result = swp_val;
			default:
				result = mem;
		endcase
	end

endmodule

// File: sim/ess_asserts.sv
// Checker for ess_exec, bound to its ports.
// Assumes properties may be disabled while ce is low, since the block freezes then.
`timescale 1ns/1ps
module ess_asserts
	import ess_pkg::*;
(
	// Clock, reset, request
	input wire logic          clock,
	input wire logic          nrst,
	input wire logic          ce,
	input wire logic          req_valid,
	input wire logic          req_ready,
	input wire ess_req_type   req,
	// Completion and datapath
	input wire logic          done,
	input wire logic          skip_dummy,
	input wire logic          mem_rd_en,
	input wire logic [7:0]    mem_rdata,
	input wire logic          mem_we,
	input wire logic [7:0]    mem_wdata,
	input wire logic [7:0]    acc_in,
	input wire logic          acc_we,
	input wire logic [7:0]    acc_wdata,
	input wire logic          flags_we,
	input wire ess_flags_type flags_wdata
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst || !ce);
	ess_op_type op_q;
	wire        take = ce && req_valid && req_ready;
	// Operation of the instruction in flight
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			op_q <= ESS_OP_INC_SKIP_ZERO_MEM;
		else if (take)
			op_q <= req.op;
	property p_time; take |-> ##3 (done && !skip_dummy) or ##3 !done ##1 (done && skip_dummy); endproperty
	a_time: assert property (p_time) else $error("wrong instruction length");
	property p_inc; op_q == ESS_OP_INC_SKIP_ZERO_MEM && mem_we |->
		mem_wdata == $past(mem_rdata) + 8'h01 ##1 skip_dummy == ($past(mem_wdata) == 8'h00); endproperty
	a_inc: assert property (p_inc) else $error("bad increment or skip");
	property p_inca; op_q == ESS_OP_INC_SKIP_ZERO_TO_ACC && acc_we |->
		!mem_we && acc_wdata == $past(mem_rdata) + 8'h01; endproperty
	a_inca: assert property (p_inca) else $error("bad increment to acc");
	property p_nz; op_q == ESS_OP_SKIP_IF_NONZERO && mem_rd_en |->
		##3 skip_dummy == ($past(mem_rdata, 2) != 8'h00); endproperty
	a_nz: assert property (p_nz) else $error("bad nonzero skip");
	property p_sub; op_q == ESS_OP_SUB_MEM_FROM_ACC && acc_we |->
		acc_wdata == $past(acc_in) - $past(mem_rdata); endproperty
	a_sub: assert property (p_sub) else $error("bad difference to acc");
	property p_subm; op_q == ESS_OP_SUB_MEM_FROM_ACC_TO_MEM && mem_we |->
		!acc_we && mem_wdata == $past(acc_in) - $past(mem_rdata); endproperty
	a_subm: assert property (p_subm) else $error("bad difference to memory");
	property p_flw; op_q inside {ESS_OP_SUB_MEM_FROM_ACC, ESS_OP_SUB_MEM_FROM_ACC_TO_MEM} && mem_rd_en |->
		##2 flags_we && flags_wdata.carry == ($past(acc_in) >= $past(mem_rdata)); endproperty
	a_flw: assert property (p_flw) else $error("bad flag update");
	property p_swap; op_q == ESS_OP_NIBBLE_EXCHANGE_MEM && mem_we |->
		{mem_wdata[3:0], mem_wdata[7:4]} == $past(mem_rdata) && !flags_we; endproperty
	a_swap: assert property (p_swap) else $error("bad nibble exchange");
endmodule
bind ess_exec ess_asserts u_ess_asserts (.*);

// File: sim/ess_core_model.sv
// Core-side model: data memory with one-cycle read, accumulator, flags.
// Assumes the bench presets contents by hierarchical writes.
`timescale 1ns/1ps
module ess_core_model
	import ess_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          mem_rd_en,
	input  wire logic [7:0]    mem_addr,
	input  wire logic          mem_we,
	input  wire logic [7:0]    mem_wdata,
	input  wire logic          acc_we,
	input  wire logic [7:0]    acc_wdata,
	input  wire logic          flags_we,
	input  wire ess_flags_type flags_wdata,
	output logic [7:0]         mem_rdata,
	output logic [7:0]         acc,
	output ess_flags_type      flags
);
	logic [7:0] mem [256];
	// Read data valid one cycle after the strobe, scrambled otherwise
	always @(posedge clock)
	begin
		mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (acc_we)
			acc <= acc_wdata;
		if (flags_we)
			flags <= flags_wdata;
	end
endmodule

// File: sim/tb.sv
// Self-checking bench for ess_exec with the core-side model.
// Assumes ce is high except in the stall scenario; memory, acc and flags are preset in the model.
`timescale 1ns/1ps
module tb;
	import ess_pkg::*;
	logic          clock = 1'b0;
	logic          nrst = 1'b0;
	logic          ce = 1'b1;
	logic          req_valid = 1'b0;
	ess_req_type   req = '0;
	logic          req_ready, done, skip_dummy, mem_rd_en, mem_we, acc_we, flags_we, skp;
	logic [7:0]    mem_addr, mem_rdata, mem_wdata, acc, acc_wdata;
	ess_flags_type flags, flags_wdata;
	int            fails = 0;
	int            checks = 0;
	int            cyc = 0;
	int            n;
	initial forever #2 clock = ~clock;
	ess_exec u_ess_exec (.clock, .nrst, .ce, .req_valid, .req_ready, .req, .done, .skip_dummy,
		.mem_rd_en, .mem_addr, .mem_rdata, .mem_we, .mem_wdata, .acc_in(acc), .acc_we, .acc_wdata,
		.flags_in(flags), .flags_we, .flags_wdata);
	ess_core_model u_ess_core_model (.clock, .mem_rd_en, .mem_addr, .mem_we, .mem_wdata, .acc_we,
		.acc_wdata, .flags_we, .flags_wdata, .mem_rdata, .acc, .flags);
	function automatic logic [7:0] m(input logic [7:0] a);
		return u_ess_core_model.mem[a];
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One instruction; n ends as its length in cycles
	task automatic run(input ess_op_type o, input logic [7:0] a, input logic [7:0] v, input int hold = 0);
		@(negedge clock);
		u_ess_core_model.mem[a] = v;
		req_valid = 1'b1;
		req = '{o, a};
		@(negedge clock);
		req_valid = 1'b0;
		if (hold > 0)
		begin
			ce = 1'b0;
			repeat (hold) @(negedge clock);
			ce = 1'b1;
		end
		n = 1 + hold;
		while (done !== 1'b1 && n < 12)
		begin
			@(negedge clock);
			n++;
		end
		skp = skip_dummy;
		// Commit edge follows a done without skip; let the writes land
		@(negedge clock);
	endtask
	task automatic t_inc;
		run(ESS_OP_INC_SKIP_ZERO_MEM, 8'h10, 8'hff);
		chk(m(8'h10), 8'h00);
		chk({7'h0, skp}, 8'h01);
		chk(n[7:0], 8'h04);
		run(ESS_OP_INC_SKIP_ZERO_MEM, 8'h11, 8'h41);
		chk(m(8'h11), 8'h42);
		chk(n[7:0], 8'h03);
		run(ESS_OP_INC_SKIP_ZERO_TO_ACC, 8'h20, 8'hff);
		chk(acc, 8'h00);
		chk(m(8'h20), 8'hff);
		chk(n[7:0], 8'h04);
		$display("t_inc ended");
	endtask
	task automatic t_nz_swap;
		run(ESS_OP_SKIP_IF_NONZERO, 8'h30, 8'h00);
		chk(n[7:0], 8'h03);
		run(ESS_OP_SKIP_IF_NONZERO, 8'h31, 8'h80);
		chk({7'h0, skp}, 8'h01);
		chk(n[7:0], 8'h04);
		u_ess_core_model.flags = 6'h15;
		run(ESS_OP_NIBBLE_EXCHANGE_MEM, 8'h40, 8'h3c);
		chk(m(8'h40), 8'hc3);
		chk({2'h0, flags}, 8'h15);
		$display("t_nz_swap ended");
	endtask
	task automatic t_sub;
		u_ess_core_model.acc = 8'h10;
		run(ESS_OP_SUB_MEM_FROM_ACC, 8'h50, 8'h20);
		chk(acc, 8'hf0);
		chk({7'h0, flags.carry}, 8'h00);
		chk({2'h0, flags}, 8'h0a);
		u_ess_core_model.acc = 8'h30;
		run(ESS_OP_SUB_MEM_FROM_ACC_TO_MEM, 8'h51, 8'h30);
		chk(m(8'h51), 8'h00);
		chk(acc, 8'h30);
		chk({6'h0, flags.carry, flags.zero}, 8'h03);
		chk({2'h0, flags}, 8'h1d);
		$display("t_sub ended");
	endtask
	// Clock enable low for two cycles in the read state stretches the instruction
	task automatic t_stall;
		run(ESS_OP_INC_SKIP_ZERO_MEM, 8'h60, 8'h7f, 2);
		chk(m(8'h60), 8'h80);
		chk({7'h0, skp}, 8'h00);
		chk(n[7:0], 8'h05);
		$display("t_stall ended");
	endtask
	task automatic end_of_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		u_ess_core_model.flags = ESS_FLAGS_RST;
		repeat (20) @(negedge clock);
		nrst = 1'b1;
		t_inc();
		t_nz_swap();
		t_sub();
		t_stall();
		end_of_test();
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 500)
		begin
			fails++;
			end_of_test();
		end
	end
endmodule
